// *** testbench/lin_bus_model.sv ***
// Behavioural model of the bus transceiver that drives the monitored pins.
`timescale 1ns/10ps
module lin_bus_model (
    input wire logic clk_i, // System clock.
    input wire logic tx_dom_i, // Request a dominant transmit line.
    input wire logic rx_dom_i, // Request a dominant bus.
    input wire logic pol_i, // Level that counts as dominant on the transmit line.
    output logic tx_line_o, // Transmit line pin.
    output logic rx_line_o // Bus receive pin.
);
    // The bus has a pull-up, so a released bus reads recessive high.
    initial begin
        tx_line_o = 1'b1;
        rx_line_o = 1'b1;
    end
    always @(posedge clk_i) begin
        tx_line_o <= tx_dom_i ? pol_i : ~pol_i;
        rx_line_o <= ~rx_dom_i;
    end
endmodule

// *** testbench/tb.sv ***
// Self-checking bench for the dominant fault monitor.
`include "lin_fault_cfg.svh"
`timescale 1ns/10ps
module tb;
    logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic tx_dom = 1'b0, rx_dom = 1'b0, pol = 1'b0;
    logic [17:0] adr = 18'h0_0000;
    logic [3:0] sel = 4'h0;
    logic [31:0] dat = 32'h0000_0000, wb_dat_o;
    logic wb_ack_o, irq_o, wake_o, tx_line, rx_line;
    int error_cnt = 0, num_checks = 0;
    initial begin
        forever #25 clk_i = ~clk_i;
    end
    lin_dominant_fault_monitor u_lin_dominant_fault_monitor (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .tx_line_i(tx_line), .rx_line_i(rx_line), .irq_o(irq_o), .wake_o(wake_o));
    lin_bus_model u_lin_bus_model (.clk_i(clk_i), .tx_dom_i(tx_dom), .rx_dom_i(rx_dom), .pol_i(pol),
        .tx_line_o(tx_line), .rx_line_o(rx_line));
    // ============================================================
    // Access and compare tasks.
    task automatic end_sim();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_pin(input logic got, input logic exp);
        chk_reg({31'h0000_0000, got}, {31'h0000_0000, exp});
    endtask
    // A classic single cycle; the wait ends only on ack or the bench limit.
    task automatic wb(input logic w, input logic [15:0] idx, input logic [7:0] d, output logic [31:0] q);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        sel <= 4'hf;
        adr <= {idx, 2'b00};
        dat <= {24'h00_0000, d};
        do begin
            @(posedge clk_i);
        end while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task automatic wr(input logic [15:0] idx, input logic [7:0] d);
        logic [31:0] q;
        wb(1'b1, idx, d, q);
    endtask
    task automatic rd(input logic [15:0] idx, input logic [7:0] e);
        logic [31:0] q;
        wb(1'b0, idx, 8'h00, q);
        chk_reg(q, {24'h00_0000, e});
    endtask
    task automatic wait_n(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    // ============================================================
    // Watchdog and main sequence.
    initial begin
        wait_n(20000);
        error_cnt++;
        end_sim();
    end
    initial begin
        wait_n(2);
        rst_i <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            rd(16'ha0b0 + 16'(i), 8'h00);
        end
        wr(16'ha0b8, 8'hff);
        rd(16'ha0b8, 8'h00);
        // Two slow ticks must fall in one dominant stretch, so short pulses never look stuck.
        wr(`IDX_STUCK_ACTIVE, 8'h01);
        rd(`IDX_STUCK_ACTIVE, 8'h01);
        wr(`IDX_TX_TO_LOW, 8'h05);
        wr(`IDX_TX_TO_HIGH, 8'h01);
        rd(`IDX_TX_TO_HIGH, 8'h01);
        wr(`IDX_TIMEOUT_CFG, 8'h01);
        tx_dom <= 1'b1;
        wait_n(250);
        chk_pin(irq_o, 1'b0);
        wait_n(40);
        chk_pin(irq_o, 1'b1);
        chk_pin(wake_o, 1'b0);
        tx_dom <= 1'b0;
        wait_n(20);
        rd(`IDX_TIMEOUT_CFG, 8'h05);
        wr(`IDX_TIMEOUT_CFG, 8'h05);
        rd(`IDX_TIMEOUT_CFG, 8'h01);
        chk_pin(irq_o, 1'b0);
        tx_dom <= 1'b1;
        wait_n(200);
        tx_dom <= 1'b0;
        wait_n(10);
        tx_dom <= 1'b1;
        wait_n(200);
        chk_pin(irq_o, 1'b0);
        tx_dom <= 1'b0;
        // The transmit line now counts as dominant when high.
        wr(`IDX_TIMEOUT_CFG, 8'h50);
        pol <= 1'b1;
        wait_n(10);
        tx_dom <= 1'b1;
        wait_n(290);
        chk_pin(wake_o, 1'b1);
        chk_pin(irq_o, 1'b0);
        tx_dom <= 1'b0;
        wr(`IDX_TIMEOUT_CFG, 8'h04);
        pol <= 1'b0;
        wr(`IDX_RX_TO_LOW, 8'h02);
        wr(`IDX_TIMEOUT_CFG, 8'h86);
        rd(`IDX_RX_TO_LOW, 8'h02);
        rx_dom <= 1'b1;
        wait_n(8);
        chk_pin(irq_o, 1'b0);
        wait_n(12);
        chk_pin(irq_o, 1'b1);
        chk_pin(wake_o, 1'b0);
        rx_dom <= 1'b0;
        wait_n(10);
        rd(`IDX_TIMEOUT_CFG, 8'h8a);
        wr(`IDX_TIMEOUT_CFG, 8'ha8);
        rx_dom <= 1'b1;
        wait_n(20);
        chk_pin(wake_o, 1'b1);
        chk_pin(irq_o, 1'b0);
        rx_dom <= 1'b0;
        wr(`IDX_TIMEOUT_CFG, 8'h88);
        rd(`IDX_STUCK_WAKE_CFG, 8'h40);
        wr(`IDX_STUCK_WAKE_CFG, 8'h50);
        chk_pin(wake_o, 1'b0);
        rx_dom <= 1'b1;
        wait_n(3);
        rx_dom <= 1'b0;
        wait_n(10);
        chk_pin(wake_o, 1'b1);
        rd(`IDX_STUCK_WAKE_CFG, 8'h50);
        wr(`IDX_STUCK_WAKE_CFG, 8'h50);
        rd(`IDX_STUCK_WAKE_CFG, 8'h10);
        wr(`IDX_STUCK_WAKE_CFG, 8'h20);
        rx_dom <= 1'b1;
        wait_n(2 * `SLOW_TICK_CYCLES + 30);
        rd(`IDX_STUCK_WAKE_CFG, 8'he0);
        chk_pin(irq_o, 1'b1);
        rx_dom <= 1'b0;
        end_sim();
    end
endmodule

// *** verilog/dominant_timer.sv ***
// Counts ticks while a line stays dominant and fires once at the limit.
`timescale 1ns/10ps
module dominant_timer
    import lin_fault_pkg::*;
(
    input wire logic clk_i, // System clock.
    input wire logic rst_i, // Synchronous reset, active high.
    input wire logic dominant_i, // Line is dominant.
    input wire logic tick_i, // Oscillator tick.
    input wire logic [16:0] limit_i, // Programmed timeout.
    output logic fire_o // One-cycle fault pulse.
);
    logic [16:0] cnt_reg;
    logic done_reg;

    // ============================================================
    // Counter
    always_ff @(posedge clk_i) begin
        if (rst_i || !dominant_i) begin
            cnt_reg <= 17'h0_0000;
            done_reg <= 1'b0;
            fire_o <= 1'b0;
        end else if (tick_i && !done_reg) begin
            if (cnt_reg == limit_i) begin
                done_reg <= 1'b1;
                fire_o <= 1'b1;
            end else begin
                cnt_reg <= cnt_reg + 17'h0_0001;
                fire_o <= 1'b0;
            end
        end else begin
            fire_o <= 1'b0;
        end
    end

    // A fault pulse needs a line that was dominant in the previous cycle too.
    AST_FIRE_NEEDS_DOMINANT: assert property (@(posedge clk_i) disable iff (rst_i)
        fire_o |-> $past(dominant_i) && $past(cnt_reg) == $past(limit_i))
        else $error("fault fired without a full dominant count");
endmodule

// *** verilog/lin_dominant_fault_monitor.sv ***
// Top of the bus dominant fault and wakeup monitor with its Wishbone registers.
`include "lin_fault_cfg.svh"
`timescale 1ns/10ps
module lin_dominant_fault_monitor
    import lin_fault_pkg::*;
(
    input wire logic clk_i, // System clock, 20 MHz.
    input wire logic rst_i, // Synchronous reset, active high.
    input wire logic wb_cyc_i, // Wishbone cycle.
    input wire logic wb_stb_i, // Wishbone strobe.
    input wire logic wb_we_i, // Wishbone write enable.
    input wire logic [17:0] wb_adr_i, // Wishbone byte address.
    input wire logic [3:0] wb_sel_i, // Wishbone byte selects.
    input wire logic [31:0] wb_dat_i, // Wishbone write data.
    output logic [31:0] wb_dat_o, // Wishbone read data.
    output logic wb_ack_o, // Wishbone acknowledge.
    input wire logic tx_line_i, // Monitored transmit line pin.
    input wire logic rx_line_i, // Bus receive line pin.
    output logic irq_o, // Interrupt request, active high.
    output logic wake_o // Wakeup request, active high.
);
    wb_req_t req;
    logic access;
    logic wr;
    logic wr_cfg;
    logic wr_wake;
    logic [7:0] wbyte;
    logic [7:0] rd_byte;

    logic [7:0] cfg_reg;
    logic [7:0] tx_low_reg;
    logic [7:0] tx_high_reg;
    logic [7:0] rx_low_reg;
    logic [7:0] rx_high_reg;
    logic [7:0] clear_width_reg;
    logic [7:0] active_width_reg;
    logic [7:0] wake_cfg_reg;

    logic [15:0] tx_timeout_value;
    logic [16:0] rx_timeout_value;
    logic [1:0][16:0] limits;
    logic [1:0] dom;
    logic [1:0] fire;

    logic tx_s1_reg;
    logic tx_s2_reg;
    logic tx_s3_reg;
    logic tx_level_reg;
    logic rx_s1_reg;
    logic rx_s2_reg;
    logic rx_s3_reg;
    logic rx_level_reg;
    logic rx_level_prev_reg;

    logic [9:0] slow_cnt_reg;
    logic slow_tick_reg;
    logic osc_tick;
    logic stuck_level;
    logic stuck_event;
    logic bus_event;

    logic irq_next;
    logic wake_next;

    localparam logic [9:0] SLOW_LAST = 10'(`SLOW_TICK_CYCLES - 1);

    // ============================================================
    // Wishbone slave
    assign req = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i, idx: wb_adr_i[17:2], sel: wb_sel_i, dat: wb_dat_i};
    assign access = req.cyc && req.stb && !wb_ack_o;
    // Only byte lane 0 carries data; a write without it changes nothing.
    assign wr = access && req.we && req.sel[0];
    assign wbyte = req.dat[7:0];
    assign wr_cfg = wr && (req.idx == `IDX_TIMEOUT_CFG);
    assign wr_wake = wr && (req.idx == `IDX_STUCK_WAKE_CFG);

    always_comb begin
        case (req.idx)
            `IDX_TIMEOUT_CFG: rd_byte = cfg_reg;
            `IDX_TX_TO_LOW: rd_byte = tx_low_reg;
            `IDX_TX_TO_HIGH: rd_byte = tx_high_reg;
            `IDX_RX_TO_LOW: rd_byte = rx_low_reg;
            `IDX_RX_TO_HIGH: rd_byte = rx_high_reg;
            `IDX_STUCK_CLEAR: rd_byte = clear_width_reg;
            `IDX_STUCK_ACTIVE: rd_byte = active_width_reg;
            `IDX_STUCK_WAKE_CFG: rd_byte = wake_cfg_reg;
            default: rd_byte = 8'h00;
        endcase
    end

    // Every request, mapped or not, is acknowledged one cycle after it is seen.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= access;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (access && !req.we) begin
            wb_dat_o <= {24'h00_0000, rd_byte};
        end else begin
            wb_dat_o <= 32'h0000_0000;
        end
    end

    // ============================================================
    // Plain data registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tx_low_reg <= `RESET_BYTE;
            tx_high_reg <= `RESET_BYTE;
            rx_low_reg <= `RESET_BYTE;
            rx_high_reg <= `RESET_BYTE;
            clear_width_reg <= `RESET_BYTE;
            active_width_reg <= `RESET_BYTE;
        end else if (wr) begin
            case (req.idx)
                `IDX_TX_TO_LOW: tx_low_reg <= wbyte;
                `IDX_TX_TO_HIGH: tx_high_reg <= wbyte;
                `IDX_RX_TO_LOW: rx_low_reg <= wbyte;
                `IDX_RX_TO_HIGH: rx_high_reg <= wbyte;
                `IDX_STUCK_CLEAR: clear_width_reg <= wbyte;
                `IDX_STUCK_ACTIVE: active_width_reg <= wbyte;
                default: begin
                end
            endcase
        end
    end

    // ============================================================
    // Timeout configuration register
    // Writable control bits are stored directly; the two fault flags set from
    // the timers and clear by a written one, and a set in the same cycle wins.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cfg_reg <= `RESET_BYTE;
        end else begin
            if (wr_cfg) begin
                cfg_reg[`CFG_TX_IRQ_EN] <= wbyte[`CFG_TX_IRQ_EN];
                cfg_reg[`CFG_RX_IRQ_EN] <= wbyte[`CFG_RX_IRQ_EN];
                cfg_reg[`CFG_TX_WAKE_EN] <= wbyte[`CFG_TX_WAKE_EN];
                cfg_reg[`CFG_RX_WAKE_EN] <= wbyte[`CFG_RX_WAKE_EN];
                cfg_reg[`CFG_TX_POL] <= wbyte[`CFG_TX_POL];
                cfg_reg[`CFG_RX_TO_BIT0] <= wbyte[`CFG_RX_TO_BIT0];
            end
            cfg_reg[`CFG_TX_FLAG] <= fire[0] || (cfg_reg[`CFG_TX_FLAG] && !(wr_cfg && wbyte[`CFG_TX_FLAG]));
            cfg_reg[`CFG_RX_FLAG] <= fire[1] || (cfg_reg[`CFG_RX_FLAG] && !(wr_cfg && wbyte[`CFG_RX_FLAG]));
        end
    end

    // ============================================================
    // Stuck wakeup configuration register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wake_cfg_reg <= `RESET_BYTE;
        end else begin
            if (wr_wake) begin
                wake_cfg_reg[`WK_STUCK_EN] <= wbyte[`WK_STUCK_EN];
                wake_cfg_reg[`WK_BUS_EN] <= wbyte[`WK_BUS_EN];
                wake_cfg_reg[3:0] <= wbyte[3:0];
            end
            wake_cfg_reg[`WK_STUCK_FLAG] <= stuck_event
                || (wake_cfg_reg[`WK_STUCK_FLAG] && !(wr_wake && wbyte[`WK_STUCK_FLAG]));
            wake_cfg_reg[`WK_BUS_FLAG] <= bus_event
                || (wake_cfg_reg[`WK_BUS_FLAG] && !(wr_wake && wbyte[`WK_BUS_FLAG]));
        end
    end

    // ============================================================
    // Pin synchronisers
    // A level counts only once the second and third stages agree.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tx_s1_reg <= 1'b1;
            tx_s2_reg <= 1'b1;
            tx_s3_reg <= 1'b1;
            tx_level_reg <= 1'b1;
        end else begin
            tx_s1_reg <= tx_line_i;
            tx_s2_reg <= tx_s1_reg;
            tx_s3_reg <= tx_s2_reg;
            if (tx_s2_reg == tx_s3_reg) begin
                tx_level_reg <= tx_s3_reg;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rx_s1_reg <= 1'b1;
            rx_s2_reg <= 1'b1;
            rx_s3_reg <= 1'b1;
            rx_level_reg <= 1'b1;
            rx_level_prev_reg <= 1'b1;
        end else begin
            rx_s1_reg <= rx_line_i;
            rx_s2_reg <= rx_s1_reg;
            rx_s3_reg <= rx_s2_reg;
            rx_level_prev_reg <= rx_level_reg;
            if (rx_s2_reg == rx_s3_reg) begin
                rx_level_reg <= rx_s3_reg;
            end
        end
    end

    // ============================================================
    // Oscillator ticks
    // The internal oscillator runs at the system rate here, so it ticks every cycle.
    assign osc_tick = (`OSC_TICK_CYCLES == 1) ? 1'b1 : slow_tick_reg;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            slow_cnt_reg <= 10'h000;
            slow_tick_reg <= 1'b0;
        end else if (slow_cnt_reg == SLOW_LAST) begin
            slow_cnt_reg <= 10'h000;
            slow_tick_reg <= 1'b1;
        end else begin
            slow_cnt_reg <= slow_cnt_reg + 10'h001;
            slow_tick_reg <= 1'b0;
        end
    end

    // ============================================================
    // Dominant timeout timers
    assign tx_timeout_value = {tx_high_reg, tx_low_reg};
    assign rx_timeout_value = {rx_high_reg, rx_low_reg, cfg_reg[`CFG_RX_TO_BIT0]};
    assign limits[0] = {1'b0, tx_timeout_value};
    assign limits[1] = rx_timeout_value;
    // The polarity bit names the transmit level that counts as dominant.
    assign dom[0] = (tx_level_reg == cfg_reg[`CFG_TX_POL]);
    assign dom[1] = !rx_level_reg;

    generate
        for (genvar ch = 0; ch < 2; ch++) begin : g_timer
            dominant_timer u_timer (
                .clk_i(clk_i),
                .rst_i(rst_i),
                .dominant_i(dom[ch]),
                .tick_i(osc_tick),
                .limit_i(limits[ch]),
                .fire_o(fire[ch])
            );
        end
    endgenerate

    // ============================================================
    // Bus stuck and bus wakeup detection
    stuck_detector u_stuck (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .dominant_i(dom[1]),
        .tick_i(slow_tick_reg),
        .active_i(active_width_reg),
        .clear_i(clear_width_reg),
        .stuck_o(stuck_level),
        .event_o(stuck_event)
    );

    // A wakeup is the bus going dominant while it is not stuck; the filter
    // length field is stored but not applied, so short glitches count too.
    assign bus_event = rx_level_prev_reg && !rx_level_reg && !stuck_level;

    // ============================================================
    // Interrupt and wakeup outputs
    always_comb begin
        irq_next = (cfg_reg[`CFG_TX_FLAG] && cfg_reg[`CFG_TX_IRQ_EN])
            || (cfg_reg[`CFG_RX_FLAG] && cfg_reg[`CFG_RX_IRQ_EN])
            || (wake_cfg_reg[`WK_STUCK_FLAG] && wake_cfg_reg[`WK_STUCK_EN])
            || (wake_cfg_reg[`WK_BUS_FLAG] && wake_cfg_reg[`WK_BUS_EN]);
        wake_next = (cfg_reg[`CFG_TX_FLAG] && cfg_reg[`CFG_TX_WAKE_EN])
            || (cfg_reg[`CFG_RX_FLAG] && cfg_reg[`CFG_RX_WAKE_EN])
            || (wake_cfg_reg[`WK_STUCK_FLAG] && wake_cfg_reg[`WK_STUCK_EN])
            || (wake_cfg_reg[`WK_BUS_FLAG] && wake_cfg_reg[`WK_BUS_EN]);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_o <= 1'b0;
            wake_o <= 1'b0;
        end else begin
            irq_o <= irq_next;
            wake_o <= wake_next;
        end
    end

    // ============================================================
    // Assertions
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    AST_TX_VALUE: assert property (limits[0][15:8] == tx_high_reg && limits[0][7:0] == tx_low_reg)
        else $error("transmit timeout misassembled");
    AST_RX_VALUE: assert property (limits[1][0] == cfg_reg[7] && limits[1][8:1] == rx_low_reg
        && limits[1][16:9] == rx_high_reg)
        else $error("receive timeout misassembled");
    AST_TX_FLAG_SET: assert property (fire[0] |=> cfg_reg[`CFG_TX_FLAG])
        else $error("transmit fault did not set its flag");
    AST_RX_FLAG_SET: assert property (fire[1] |=> cfg_reg[`CFG_RX_FLAG])
        else $error("receive fault did not set its flag");
    AST_RX_FLAG_HOLD: assert property (cfg_reg[`CFG_RX_FLAG] && !(wr_cfg && wbyte[`CFG_RX_FLAG])
        |=> cfg_reg[`CFG_RX_FLAG])
        else $error("receive fault flag dropped by itself");
    AST_TX_FLAG_HOLD: assert property (cfg_reg[`CFG_TX_FLAG] && !(wr_cfg && wbyte[`CFG_TX_FLAG])
        |=> cfg_reg[`CFG_TX_FLAG])
        else $error("transmit fault flag dropped by itself");
    AST_IRQ_GATE: assert property (##1 irq_o == ($past(cfg_reg[3] & cfg_reg[1]) | $past(cfg_reg[2] & cfg_reg[0])
        | $past(wake_cfg_reg[7] & wake_cfg_reg[5]) | $past(wake_cfg_reg[6] & wake_cfg_reg[4])))
        else $error("interrupt not gated by its enables");
    AST_WAKE_GATE: assert property (##1 wake_o == ($past(cfg_reg[2] & cfg_reg[4]) | $past(cfg_reg[3] & cfg_reg[5])
        | $past(wake_cfg_reg[7] & wake_cfg_reg[5]) | $past(wake_cfg_reg[6] & wake_cfg_reg[4])))
        else $error("wakeup not gated by its enables");
    AST_TX_POLARITY: assert property (dom[0] == (tx_level_reg ~^ cfg_reg[6]))
        else $error("transmit polarity wrong");
    AST_STUCK_FLAG: assert property (stuck_event |=> wake_cfg_reg[`WK_STUCK_FLAG])
        else $error("stuck event did not set its flag");
    AST_BUS_FLAG_HOLD: assert property (wake_cfg_reg[`WK_BUS_FLAG] && !wr_wake |=> wake_cfg_reg[`WK_BUS_FLAG])
        else $error("bus wake flag dropped by itself");
    AST_RX_RECESSIVE: assert property (rx_level_reg |=> !fire[1])
        else $error("receive fault while recessive");
    AST_CLEAR_BY_ONE: assert property (wr_cfg && wbyte[2] && !fire[0] |=> !cfg_reg[2])
        else $error("writing one did not clear the flag");
    AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held for more than one cycle");

    CVR_TX_FAULT: cover property (fire[0] ##1 irq_o [*2]);
    CVR_RX_FAULT: cover property (fire[1]);
    CVR_STUCK: cover property (stuck_event ##[1:20] wake_o);
    CVR_BUS_WAKE: cover property (bus_event);
endmodule

// *** verilog/lin_fault_cfg.svh ***
// Constants for the bus dominant fault and wakeup monitor.
`ifndef LIN_FAULT_CFG_SVH
`define LIN_FAULT_CFG_SVH

// ============================================================
// Register indices; the byte address is four times the index.
`define IDX_TIMEOUT_CFG 16'ha0b0
`define IDX_TX_TO_LOW 16'ha0b1
`define IDX_TX_TO_HIGH 16'ha0b2
`define IDX_RX_TO_LOW 16'ha0b3
`define IDX_RX_TO_HIGH 16'ha0b4
`define IDX_STUCK_CLEAR 16'ha0b5
`define IDX_STUCK_ACTIVE 16'ha0b6
`define IDX_STUCK_WAKE_CFG 16'ha0b7

// ============================================================
// Field positions in the timeout configuration register.
`define CFG_TX_IRQ_EN 0
`define CFG_RX_IRQ_EN 1
`define CFG_TX_FLAG 2
`define CFG_RX_FLAG 3
`define CFG_TX_WAKE_EN 4
`define CFG_RX_WAKE_EN 5
`define CFG_TX_POL 6
`define CFG_RX_TO_BIT0 7

// ============================================================
// Field positions in the stuck wakeup configuration register.
`define WK_STUCK_FLAG 7
`define WK_BUS_FLAG 6
`define WK_STUCK_EN 5
`define WK_BUS_EN 4

// ============================================================
// Reset values.
`define RESET_BYTE 8'h00

// ============================================================
// Timing.
`define CLK_PERIOD_NS 50
`define OSC_PERIOD_NS 50
`define SLOW_OSC_PERIOD_NS 31250
`define OSC_TICK_CYCLES ((`OSC_PERIOD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SLOW_TICK_CYCLES ((`SLOW_OSC_PERIOD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// *** verilog/lin_fault_pkg.sv ***
// Types shared by the dominant fault monitor.
package lin_fault_pkg;

    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [15:0] idx;
        logic [3:0] sel;
        logic [31:0] dat;
    } wb_req_t;

    typedef enum logic [1:0] {
        ST_FREE = 2'b01,
        ST_STUCK = 2'b10
    } stuck_state_t;

endpackage

// *** verilog/stuck_detector.sv ***
// Detects the bus held dominant for the active width and released for the clear width.
`timescale 1ns/10ps
module stuck_detector
    import lin_fault_pkg::*;
(
    input wire logic clk_i, // System clock.
    input wire logic rst_i, // Synchronous reset, active high.
    input wire logic dominant_i, // Bus is dominant.
    input wire logic tick_i, // Slow oscillator tick.
    input wire logic [7:0] active_i, // Active width value.
    input wire logic [7:0] clear_i, // Clear width value.
    output logic stuck_o, // Stuck condition level.
    output logic event_o // One-cycle stuck event pulse.
);
    stuck_state_t state_reg;
    logic [7:0] cnt_reg;
    logic [7:0] limit;
    logic counting;

    assign limit = (state_reg == ST_STUCK) ? clear_i : active_i;
    // In the free state dominance is counted, in the stuck state recessiveness.
    assign counting = (state_reg == ST_STUCK) ? !dominant_i : dominant_i;

    // ============================================================
    // State and width counter
    always_ff @(posedge clk_i) begin
        event_o <= 1'b0;
        if (rst_i) begin
            state_reg <= ST_FREE;
            cnt_reg <= 8'h00;
            stuck_o <= 1'b0;
        end else if (!counting) begin
            cnt_reg <= 8'h00;
        end else if (tick_i) begin
            if (cnt_reg != limit) begin
                cnt_reg <= cnt_reg + 8'h01;
            end else begin
                cnt_reg <= 8'h00;
                case (state_reg)
                    ST_FREE: begin
                        state_reg <= ST_STUCK;
                        stuck_o <= 1'b1;
                        event_o <= 1'b1;
                    end
                    ST_STUCK: begin
                        state_reg <= ST_FREE;
                        stuck_o <= 1'b0;
                    end
                    default: begin
                        state_reg <= ST_FREE;
                        stuck_o <= 1'b0;
                    end
                endcase
            end
        end
    end

    AST_STUCK_ENTRY: assert property (@(posedge clk_i) disable iff (rst_i)
        event_o |-> $past(dominant_i) && $past(cnt_reg) == $past(active_i) && $past(tick_i))
        else $error("stuck event without full active width");
endmodule
